// >>> include/dpram_host_pkg.sv
package dpram_host_pkg;

  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_PWE_NS      = 20;
  localparam int T_AA_NS       = 25;
  localparam int T_SOP_NS      = 12;
  localparam int T_HD_NS       = 0;
  localparam int SYNC_STAGES   = 2;
  localparam int CNT_W         = 4;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction

  localparam logic [CNT_W-1:0] PWE_CYC  = CNT_W'(cyc_up(T_PWE_NS));
  localparam logic [CNT_W-1:0] READ_CYC =
    CNT_W'(cyc_up(T_AA_NS) + SYNC_STAGES + 1);
  localparam logic [CNT_W-1:0] SOP_CYC  = CNT_W'(cyc_up(T_SOP_NS));
  localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(cyc_up(T_HD_NS));
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // Memory port widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_WRITE_BIT  = 1;
  localparam int CTRL_FLAG_BIT   = 2;
  localparam int ST_ACTIVE_BIT   = 0;
  localparam int ST_DONE_BIT     = 1;
  localparam int ST_BUSYSEEN_BIT = 2;
  localparam int ST_INT_BIT      = 3;
  localparam int ST_BUSYLVL_BIT  = 4;
  localparam int HTRANS_ACT_BIT  = 1;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_SETUP   = 5'b00010,
    ST_STROBE  = 5'b00100,
    ST_HOLD    = 5'b01000,
    ST_RECOVER = 5'b10000
  } state_t;

  typedef struct packed {
    logic cs_n;
    logic flag_n;
    logic we_n;
    logic oe_n;
    logic dq_oe_n;
  } pin_ctl_t;

  localparam pin_ctl_t PINS_QUIET = 5'h1F;

  typedef struct packed {
    logic wr;
    logic flag;
  } cmd_t;

  localparam cmd_t CMD_NONE = 2'h0;

endpackage

// >>> core/dpram_port_host.sv
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns

// Summary of operation
// - Write strobe high whenever address changes
// - Address valid before select falls on reads
// - Separate flag select pulse per flag read
// - Memory select stays high through flag cycles
// - Never both selects low together
// - Flag value from bit zero driven on every data bit
module dpram_port_host
  import dpram_host_pkg::*;
(
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              SYS_RST,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  output logic      [31:0]       HRDATA,
  // Memory port pins
  output logic      [ADDR_W-1:0] MEM_ADDR,
  input  wire logic [DATA_W-1:0] MEM_DQ_IN,
  output logic      [DATA_W-1:0] MEM_DQ_OUT,
  output logic                   MEM_DQ_OE_N,
  output logic                   MEM_CS_N,
  output logic                   MEM_WE_N,
  output logic                   MEM_OE_N,
  output logic                   MEM_FLAG_SELECT_N,
  input  wire logic              MEM_BUSY_N,
  input  wire logic              MEM_INT_N
);

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [DATA_W+1:0] sync1_reg;
  logic [DATA_W+1:0] sync2_reg;
  logic [DATA_W-1:0] dq_sync;
  logic              busy_n_sync;
  logic              int_n_sync;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= {MEM_BUSY_N, MEM_INT_N, MEM_DQ_IN};
      sync2_reg <= sync1_reg;
    end
  end

  assign busy_n_sync = sync2_reg[DATA_W+1];
  assign int_n_sync  = sync2_reg[DATA_W];
  assign dq_sync     = sync2_reg[DATA_W-1:0];

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic              dph_wr_reg;
  logic [7:0]        dph_ofs_reg;
  logic [ADDR_W-1:0] addr_cfg_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              done_reg;
  logic              busy_seen_reg;
  logic [31:0]       hrdata_reg;
  logic [31:0]       status_word;
  logic              addr_phase;
  logic              start_req;
  cmd_t              req_cmd;
  state_t            state_reg;
  state_t            state_next;

  assign addr_phase = HSEL && HTRANS[HTRANS_ACT_BIT] && HREADY;
  assign HREADYOUT  = 1'b1;
  assign HRESP      = 1'b0;
  assign HRDATA     = hrdata_reg;

  always_comb begin
    status_word = WORD_ZERO;
    status_word[ST_ACTIVE_BIT]   = (state_reg != ST_IDLE);
    status_word[ST_DONE_BIT]     = done_reg;
    status_word[ST_BUSYSEEN_BIT] = busy_seen_reg;
    status_word[ST_INT_BIT]      = !int_n_sync;
    status_word[ST_BUSYLVL_BIT]  = !busy_n_sync;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      dph_wr_reg  <= 1'b0;
      dph_ofs_reg <= 8'h00;
    end else begin
      dph_wr_reg  <= addr_phase && HWRITE;
      dph_ofs_reg <= HADDR[7:0];
    end
  end

  // Read data taken in the address phase, so zero wait states
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      hrdata_reg <= WORD_ZERO;
    end else if (addr_phase && !HWRITE) begin
      if (HADDR[7:0] == OFS_ADDR) begin
        hrdata_reg <= {{(32-ADDR_W){1'b0}}, addr_cfg_reg};
      end else if (HADDR[7:0] == OFS_WDATA) begin
        hrdata_reg <= {{(32-DATA_W){1'b0}}, wdata_reg};
      end else if (HADDR[7:0] == OFS_RDATA) begin
        hrdata_reg <= {{(32-DATA_W){1'b0}}, rdata_reg};
      end else if (HADDR[7:0] == OFS_STATUS) begin
        hrdata_reg <= status_word;
      end else begin
        hrdata_reg <= WORD_ZERO;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      addr_cfg_reg <= '0;
      wdata_reg    <= '0;
    end else if (dph_wr_reg && dph_ofs_reg == OFS_ADDR) begin
      addr_cfg_reg <= HWDATA[ADDR_W-1:0];
    end else if (dph_wr_reg && dph_ofs_reg == OFS_WDATA) begin
      wdata_reg <= HWDATA[DATA_W-1:0];
    end
  end

  // Start is dropped while a transfer is running
  assign start_req = dph_wr_reg && (dph_ofs_reg == OFS_CTRL) &&
                     HWDATA[CTRL_START_BIT] && (state_reg == ST_IDLE);
  assign req_cmd   = {HWDATA[CTRL_WRITE_BIT], HWDATA[CTRL_FLAG_BIT]};

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  cmd_t              cmd_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              cnt_last;
  pin_ctl_t          pins_reg;
  pin_ctl_t          pins_next;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic              status_clr;

  assign cnt_last = (cnt_reg == CNT_ZERO);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_req) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_next = ST_STROBE;
      end
      ST_STROBE: begin
        if (cnt_last) begin
          state_next = cmd_reg.wr ? ST_HOLD : ST_RECOVER;
        end
      end
      ST_HOLD: begin
        if (cnt_last) begin
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (cnt_last) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        case (state_next)
          ST_STROBE:  cnt_reg <= cmd_reg.wr ? PWE_CYC - CNT_ONE
                                            : READ_CYC - CNT_ONE;
          ST_HOLD:    cnt_reg <= HOLD_CYC - CNT_ONE;
          ST_RECOVER: cnt_reg <= SOP_CYC - CNT_ONE;
          default:    cnt_reg <= CNT_ZERO;
        endcase
      end else if (!cnt_last) begin
        cnt_reg <= cnt_reg - CNT_ONE;
      end
    end
  end

  // Address and data latched once per transfer, never mid-strobe
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cmd_reg      <= CMD_NONE;
      mem_addr_reg <= '0;
      dq_out_reg   <= '0;
    end else if (start_req) begin
      cmd_reg      <= req_cmd;
      mem_addr_reg <= addr_cfg_reg;
      if (req_cmd.flag) begin
        dq_out_reg <= {DATA_W{wdata_reg[FLAG_BIT]}};
      end else begin
        dq_out_reg <= wdata_reg;
      end
    end
  end

  // Pin levels derived from the next state so pins come from flops
  always_comb begin
    pins_next = PINS_QUIET;
    case (state_next)
      ST_SETUP: begin
        // Command register loads on this same edge, so use the request
        pins_next.dq_oe_n = !req_cmd.wr;
      end
      ST_STROBE: begin
        // Exactly one select: flag cycles keep memory select high
        pins_next.cs_n    = cmd_reg.flag;
        pins_next.flag_n  = !cmd_reg.flag;
        pins_next.we_n    = !cmd_reg.wr;
        // Output enable stays high on writes so device outputs stay off
        pins_next.oe_n    = cmd_reg.wr;
        pins_next.dq_oe_n = !cmd_reg.wr;
      end
      ST_HOLD: begin
        pins_next.dq_oe_n = 1'b0;
      end
      default: begin
        pins_next = PINS_QUIET;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pins_reg <= PINS_QUIET;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign MEM_ADDR          = mem_addr_reg;
  assign MEM_DQ_OUT        = dq_out_reg;
  assign MEM_DQ_OE_N       = pins_reg.dq_oe_n;
  assign MEM_CS_N          = pins_reg.cs_n;
  assign MEM_WE_N          = pins_reg.we_n;
  assign MEM_OE_N          = pins_reg.oe_n;
  assign MEM_FLAG_SELECT_N = pins_reg.flag_n;

  // ----------------------------------------------------------------
  // Results and status
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rdata_reg <= '0;
    end else if (state_reg == ST_STROBE && cnt_last && !cmd_reg.wr) begin
      rdata_reg <= dq_sync;
    end
  end

  assign status_clr = dph_wr_reg && (dph_ofs_reg == OFS_STATUS);

  // Set beats a clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      done_reg      <= 1'b0;
      busy_seen_reg <= 1'b0;
    end else begin
      if (state_reg == ST_RECOVER && cnt_last) begin
        done_reg <= 1'b1;
      end else if (status_clr && HWDATA[ST_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      // Write may have been dropped by the device; software retries
      if (state_reg == ST_STROBE && !busy_n_sync) begin
        busy_seen_reg <= 1'b1;
      end else if (status_clr && HWDATA[ST_BUSYSEEN_BIT]) begin
        busy_seen_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_addr_still_wr: assert property (
    !MEM_WE_N |-> $stable(MEM_ADDR))
    else $error("Address moved while write strobe low");
  a_one_select: assert property (
    !(!MEM_CS_N && !MEM_FLAG_SELECT_N))
    else $error("Both selects low");
  a_addr_before_cs: assert property (
    $fell(MEM_CS_N) && MEM_WE_N |-> $stable(MEM_ADDR) && $past(MEM_WE_N))
    else $error("Read select fell without settled address");
  a_flag_cs_high: assert property (
    $fell(MEM_FLAG_SELECT_N) |-> MEM_CS_N[*3])
    else $error("Memory select low during flag cycle");
  a_flag_reselect: assert property (
    $rose(MEM_FLAG_SELECT_N) |-> MEM_FLAG_SELECT_N[*2])
    else $error("Flag select not released between flag cycles");
  a_write_pulse: assert property (
    $fell(MEM_WE_N) |-> (!MEM_WE_N && !MEM_DQ_OE_N)[*3])
    else $error("Write pulse too short or data not driven");
  a_flag_bit_zero: assert property (
    !MEM_FLAG_SELECT_N && !MEM_WE_N |-> MEM_DQ_OUT[FLAG_BIT] ==
      wdata_reg[FLAG_BIT])
    else $error("Flag write value not on bit zero");
  a_no_fight: assert property (
    !MEM_OE_N |-> MEM_DQ_OE_N && MEM_WE_N)
    else $error("Host drives data while device output enabled");
  a_read_done: assert property (
    $rose(MEM_OE_N) && !$past(MEM_CS_N) |-> ##[1:4] done_reg)
    else $error("Read did not complete");

  c_mem_read:  cover property ($rose(MEM_OE_N) && !$past(MEM_CS_N));
  c_mem_write: cover property ($rose(MEM_WE_N) && !$past(MEM_CS_N));
  c_flag_op:   cover property ($rose(MEM_FLAG_SELECT_N));
  c_busy_seen: cover property ($rose(busy_seen_reg));

endmodule

// >>> verification/dpram_side_model.sv
`timescale 1ns/1ns
module dpram_side_model
  import dpram_host_pkg::*;
(
  // Host pins
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_from_host,
  input  wire logic              cs_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic              flag_select_n,
  output logic      [DATA_W-1:0] dq_to_host,
  output logic                   driving,
  // Arbitration and mailbox
  input  wire logic              busy_n,
  output logic                   int_n
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic              own [2][8];
  logic              pend [2][8];
  logic [DATA_W-1:0] last_q;
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] w_data;
  logic [ADDR_W-1:0] w_addr;
  logic              w_flag;
  logic              wr_act;
  logic              far_int_n;

  initial begin
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        own[p][i]  = 1'b0;
        pend[p][i] = 1'b0;
      end
    end
    int_n     = 1'b1;
    far_int_n = 1'b1;
    last_q    = 8'h00;
  end

  // -------------------------------------------------------------
  // Pin decode
  // -------------------------------------------------------------
  assign wr_act  = !we_n && (cs_n ^ flag_select_n);
  assign driving = we_n && !oe_n && (cs_n ^ flag_select_n);
  assign rd_val  = cs_n ? {DATA_W{~own[0][addr[2:0]]}} : mem[addr];
  // Released lines show the inverse so a stale value never matches
  assign dq_to_host = driving ? rd_val : ~last_q;
  always @* if (driving) last_q = rd_val;

  // Hold the write target while the strobe overlap lasts
  always @* begin
    if (wr_act) begin
      w_flag = !flag_select_n;
      w_addr = addr;
      w_data = dq_from_host;
    end
  end

  always @(negedge wr_act) begin
    if (w_flag === 1'b1) begin
      sem_put(0, int'(w_addr[2:0]), w_data[0]);
    end else if (busy_n && w_flag === 1'b0) begin
      mem[w_addr] = w_data;
      if (w_addr == 14'h3FFF) begin
        far_int_n = 1'b0;
      end
    end
  end

  // Port 0 is the host side, port 1 the far side
  task automatic sem_put(input int p, input int i, input logic v);
    if (!v && !own[1-p][i]) begin
      own[p][i] = 1'b1;
    end else if (!v) begin
      pend[p][i] = 1'b1;
    end else if (own[p][i]) begin
      own[p][i]     = 1'b0;
      own[1-p][i]   = pend[1-p][i];
      pend[1-p][i]  = 1'b0;
    end else begin
      pend[p][i] = 1'b0;
    end
  endtask

  task automatic other_mail();
    int_n = 1'b0;
  endtask

  always @* begin
    if (driving && !cs_n && addr == 14'h3FFE && busy_n) begin
      int_n = 1'b1;
    end
  end
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb;
  import dpram_host_pkg::*;
  logic              mclk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = WORD_ZERO;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [31:0]       hwdata = WORD_ZERO;
  logic              busy_n = 1'b1;
  wire               hready;
  wire               hresp;
  wire  [31:0]       hrdata;
  wire  [ADDR_W-1:0] mem_addr;
  wire  [DATA_W-1:0] dq_out;
  wire  [DATA_W-1:0] dq_in;
  wire               dq_oe_n, cs_n, we_n, oe_n, flag_n, int_n, driving;
  logic [ADDR_W-1:0] prev_addr = 14'h0000;
  logic              prev_sel = 1'b0;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  logic [13:0]       ma [3] = '{14'h0003, 14'h1FFF, 14'h3FFF};
  logic [7:0]        md [3] = '{8'hA5, 8'h5A, 8'hC3};

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  dpram_port_host i_dpram_port_host (.MCLK(mclk), .SYS_RST(sys_rst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
    .MEM_ADDR(mem_addr), .MEM_DQ_IN(dq_in), .MEM_DQ_OUT(dq_out),
    .MEM_DQ_OE_N(dq_oe_n), .MEM_CS_N(cs_n), .MEM_WE_N(we_n),
    .MEM_OE_N(oe_n), .MEM_FLAG_SELECT_N(flag_n), .MEM_BUSY_N(busy_n),
    .MEM_INT_N(int_n));

  dpram_side_model i_dpram_side_model (.addr(mem_addr),
    .dq_from_host(dq_out), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
    .flag_select_n(flag_n), .dq_to_host(dq_in), .driving(driving),
    .busy_n(busy_n), .int_n(int_n));

  // -------------------------------------------------------------
  // Access tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic xfer(input logic f, input logic w, input logic [13:0] a,
                      input logic [7:0] d, output logic [31:0] st);
    logic [31:0] r;
    int          n;
    bus(1'b1, OFS_ADDR, {18'h0, a}, r);
    bus(1'b1, OFS_WDATA, {24'h0, d}, r);
    bus(1'b1, OFS_CTRL, {29'h0, f, w, 1'b1}, r);
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, WORD_ZERO, st);
      n++;
    end while (st[ST_DONE_BIT] !== 1'b1 && n < 40);
    chk({31'h0, st[ST_DONE_BIT]}, 32'h1);
    bus(1'b1, OFS_STATUS, 32'h0000_0006, r);
  endtask

  task automatic rd_mem(input logic f, input logic [13:0] a,
                        input logic [7:0] e);
    logic [31:0] st;
    logic [31:0] r;
    xfer(f, 1'b0, a, 8'h00, st);
    bus(1'b0, OFS_RDATA, WORD_ZERO, r);
    chk(r, {24'h0, e});
  endtask

  // Two flops of synchronising lie between the pin and the status bit
  task automatic st_chk(input int b, input logic e);
    logic [31:0] r;
    repeat (4) @(posedge mclk);
    bus(1'b0, OFS_STATUS, WORD_ZERO, r);
    chk({31'h0, r[b]}, {31'h0, e});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // Pin watch and timeout
  // -------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (!sys_rst) begin
      chk({31'h0, cs_n | flag_n}, 32'h1);
      chk({31'h0, hresp}, 32'h0);
      if (driving === 1'b1) chk({31'h0, dq_oe_n}, 32'h1);
      if (prev_sel && !(cs_n && flag_n)) chk(mem_addr, prev_addr);
    end
    prev_addr <= mem_addr;
    prev_sel  <= !(cs_n && flag_n);
    if (cyc == 8000) begin
      fail_count++;
      complete_run();
    end
  end

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial begin
    logic [31:0] st;
    logic [31:0] r;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    chk({27'h0, cs_n, flag_n, we_n, oe_n, dq_oe_n}, 32'h1F);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF, r);
    bus(1'b0, 8'h20, WORD_ZERO, r);
    chk(r, WORD_ZERO);
    foreach (ma[i]) begin
      xfer(1'b0, 1'b1, ma[i], md[i], st);
    end
    chk({31'h0, i_dpram_side_model.far_int_n}, 32'h0);
    foreach (ma[i]) begin
      rd_mem(1'b0, ma[i], md[i]);
    end
    xfer(1'b1, 1'b1, 14'h0003, 8'hFE, st);
    rd_mem(1'b1, 14'h0003, 8'h00);
    xfer(1'b1, 1'b1, 14'h0003, 8'h01, st);
    rd_mem(1'b1, 14'h0003, 8'hFF);
    i_dpram_side_model.sem_put(1, 3, 1'b0);
    xfer(1'b1, 1'b1, 14'h0003, 8'h00, st);
    rd_mem(1'b1, 14'h0003, 8'hFF);
    i_dpram_side_model.sem_put(1, 3, 1'b1);
    rd_mem(1'b1, 14'h0003, 8'h00);
    xfer(1'b1, 1'b1, 14'h0003, 8'h01, st);
    rd_mem(1'b1, 14'h0003, 8'hFF);
    rd_mem(1'b0, 14'h0003, 8'hA5);
    i_dpram_side_model.other_mail();
    st_chk(ST_INT_BIT, 1'b1);
    busy_n <= 1'b0;
    xfer(1'b0, 1'b1, 14'h0003, 8'h77, st);
    chk(st & 32'h0000_0014, 32'h0000_0014);
    xfer(1'b0, 1'b0, 14'h3FFE, 8'h00, st);
    st_chk(ST_INT_BIT, 1'b1);
    busy_n <= 1'b1;
    rd_mem(1'b0, 14'h0003, 8'hA5);
    xfer(1'b0, 1'b0, 14'h3FFE, 8'h00, st);
    st_chk(ST_INT_BIT, 1'b0);
    complete_run();
  end
endmodule
